/* File: bench/cise_exec_monitor.sv */
`timescale 1ns/100ps
`include "cise_params.svh"

// Port-level checker of the executed subset
module cise_exec_monitor
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic instr_valid_in,
	input wire cise_pkg::cise_op_t instr_op_in,
	input wire logic [1:0] bit_sel_in,
	input wire logic [3:0] port1_in,
	input wire logic [3:0] mem_rdata_in,
	input wire logic int_entry_in,
	input wire logic instr_ready_out,
	input wire logic [3:0] acc_out,
	input wire logic carry_flag_out,
	input wire logic [3:0] idx_y_out,
	input wire logic [`CISE_SP_W-1:0] stack_pointer_out,
	input wire logic skip_pending_out,
	input wire logic [3:0] port0_out,
	input wire logic [3:0] mem_wdata_out,
	input wire logic mem_we_out,
	input wire logic clock_mode_out,
	input wire logic backup_mode_out
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic taken;
	logic act;
	logic armed_q;
	logic clk_exp_q;
	logic bak_exp_q;

	// A skipped instruction is taken but must not act
	assign taken = instr_valid_in && instr_ready_out;
	assign act = taken && !skip_pending_out;

	// Arm lasts only until the next taken instruction or an interrupt
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			armed_q <= 1'b0;
			clk_exp_q <= 1'b0;
			bak_exp_q <= 1'b0;
		end
		else
		begin
			armed_q <= int_entry_in ? 1'b0 : (taken ? act && instr_op_in == cise_pkg::CISE_POWERDOWN_ENABLE : armed_q);
			clk_exp_q <= act && armed_q && instr_op_in == cise_pkg::CISE_CLOCK_MODE_POWERDOWN;
			bak_exp_q <= act && armed_q && instr_op_in == cise_pkg::CISE_BACKUP_MODE_POWERDOWN;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	chk_port_input_acc: assert property (act && instr_op_in == cise_pkg::CISE_PORT1_INPUT_TO_ACC
		|=> acc_out == $past(port1_in)) else $error("port input did not reach acc");
	chk_port_output_latch: assert property (act && instr_op_in == cise_pkg::CISE_ACC_OUTPUT_TO_PORT0
		|=> port0_out == $past(acc_out) && $stable(acc_out)) else $error("port output wrong");
	chk_y_increment_skip: assert property (act && instr_op_in == cise_pkg::CISE_INDEX_Y_INCREMENT
		|=> idx_y_out == $past(idx_y_out) + 4'h1 && skip_pending_out == (idx_y_out == 4'h0))
		else $error("index increment or skip wrong");
	chk_rotate_carry: assert property (act && instr_op_in == cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY
		|=> {acc_out, carry_flag_out} == {$past(carry_flag_out), $past(acc_out)}) else $error("rotate wrong");
	chk_carry_clear_only: assert property (act && instr_op_in == cise_pkg::CISE_CARRY_CLEAR
		|=> !carry_flag_out && $stable(acc_out)) else $error("carry clear wrong");
	chk_bit_clear_write: assert property (act && instr_op_in == cise_pkg::CISE_MEMORY_BIT_CLEAR
		|=> mem_we_out && mem_wdata_out == ($past(mem_rdata_in) & ~(4'h1 << $past(bit_sel_in))))
		else $error("memory bit clear wrong");
	chk_return_pop_sp: assert property (act && instr_op_in == cise_pkg::CISE_SUBROUTINE_RETURN
		|=> !instr_ready_out ##1 stack_pointer_out == $past(stack_pointer_out, 2) - 3'h1)
		else $error("return timing or pointer wrong");
	chk_clock_mode_armed: assert property (clock_mode_out == clk_exp_q)
		else $error("clock mode pulse wrong");
	chk_backup_mode_armed: assert property (backup_mode_out == bak_exp_q)
		else $error("backup mode pulse wrong");
endmodule // cise_exec_monitor

/* File: bench/tb_cise_exec.sv */
`timescale 1ns/100ps
`include "cise_params.svh"

module tb_cise_exec;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic instr_valid_in = 1'b0, int_entry_in = 1'b0, b_load_in = 1'b0;
	cise_pkg::cise_op_t instr_op_in = cise_pkg::CISE_OTHER;
	logic [3:0] imm_first_in = 4'h0, imm_second_in = 4'h0, port0_in = 4'h0, port1_in = 4'h0, port2_in = 4'h0;
	logic [3:0] mem_rdata_in = 4'h0, b_value_in = 4'h0;
	logic [1:0] bit_sel_in = 2'h0;
	logic [`CISE_PC_W-1:0] int_vector_in = 13'h0100, pc_out;
	logic instr_ready_out, carry_flag_out, skip_pending_out, mem_we_out, clock_mode_out, backup_mode_out;
	logic [3:0] acc_out, idx_x_out, idx_y_out, reg_b_out, port0_out, port1_out, port2_out, mem_wdata_out;
	logic [1:0] idx_z_out;
	logic [`CISE_SP_W-1:0] stack_pointer_out;
	logic [`CISE_PORTD_BITS-1:0] port_d_out;
	logic [`CISE_DP_W-1:0] mem_raddr_out, mem_waddr_out;
	int error_cnt = 0;
	int tests_run = 0;

	cise_exec u_dut (.clk_sys_in, .rst_b_in, .instr_valid_in, .instr_op_in, .imm_first_in, .imm_second_in,
		.bit_sel_in, .port0_in, .port1_in, .port2_in, .mem_rdata_in, .int_entry_in, .int_vector_in, .b_load_in,
		.b_value_in, .instr_ready_out, .pc_out, .acc_out, .carry_flag_out, .idx_x_out, .idx_y_out, .idx_z_out,
		.reg_b_out, .stack_pointer_out, .skip_pending_out, .port0_out, .port1_out, .port2_out, .port_d_out,
		.mem_raddr_out, .mem_waddr_out, .mem_wdata_out, .mem_we_out, .clock_mode_out, .backup_mode_out);

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Wide enough for the longest packed state compare
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Valid stays up between issues so it never toggles twice in one step
	task automatic issue(input cise_pkg::cise_op_t op, input logic [3:0] a = 4'h0, input logic [3:0] b = 4'h0,
		input logic [1:0] s = 2'h0);
		int n;
		n = 0;
		while (instr_ready_out !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys_in);
			#5;
			n++;
		end
		instr_valid_in = 1'b1;
		instr_op_in = op;
		imm_first_in = a;
		imm_second_in = b;
		bit_sel_in = s;
		@(posedge clk_sys_in);
		#5;
	endtask

	task automatic idle();
		instr_valid_in = 1'b0;
		@(posedge clk_sys_in);
		#5;
	endtask

	task automatic irq();
		instr_valid_in = 1'b0;
		int_entry_in = 1'b1;
		@(posedge clk_sys_in);
		#5;
		int_entry_in = 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_ports();
		logic [3:0] pin[3] = '{4'h9, 4'h6, 4'hc};
		cise_pkg::cise_op_t op_i[3] = '{cise_pkg::CISE_PORT0_INPUT_TO_ACC, cise_pkg::CISE_PORT1_INPUT_TO_ACC,
			cise_pkg::CISE_PORT2_INPUT_TO_ACC};
		cise_pkg::cise_op_t op_o[3] = '{cise_pkg::CISE_ACC_OUTPUT_TO_PORT0, cise_pkg::CISE_ACC_OUTPUT_TO_PORT1,
			cise_pkg::CISE_ACC_OUTPUT_TO_PORT2};
		port0_in = pin[0];
		port1_in = pin[1];
		port2_in = pin[2];
		for (int i = 0; i < 3; i++)
		begin
			issue(op_i[i]);
			check("acc from port", acc_out, pin[i]);
			issue(op_o[i]);
			check("port latch", i == 0 ? port0_out : (i == 1 ? port1_out : port2_out), pin[i]);
			check("acc kept", acc_out, pin[i]);
		end
	endtask

	task automatic t_loads();
		logic [`CISE_PC_W-1:0] pc0;
		issue(cise_pkg::CISE_OTHER);
		pc0 = pc_out;
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h5);
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h9);
		check("acc load run", acc_out, 4'h5);
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h3, 4'he);
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h1, 4'h2);
		check("x load run", idx_x_out, 4'h3);
		check("y load run", idx_y_out, 4'he);
		issue(cise_pkg::CISE_INDEX_Y_INCREMENT);
		check("no skip at 15", skip_pending_out, 1'b0);
		issue(cise_pkg::CISE_INDEX_Y_INCREMENT);
		check("y wrap", idx_y_out, 4'h0);
		check("skip at 0", skip_pending_out, 1'b1);
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h7);
		check("skipped load", acc_out, 4'h5);
		check("pc advance", pc_out, pc0 + 13'h0007);
	endtask

	task automatic t_rotate();
		issue(cise_pkg::CISE_OTHER);
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h5);
		issue(cise_pkg::CISE_CARRY_CLEAR);
		issue(cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY);
		check("rotate carry", {acc_out, carry_flag_out}, 5'h05);
		issue(cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY);
		check("rotate carry in", {acc_out, carry_flag_out}, 5'h12);
		issue(cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY);
		issue(cise_pkg::CISE_CARRY_CLEAR);
		check("carry clear", {acc_out, carry_flag_out}, 5'h08);
	endtask

	task automatic t_bitclr();
		mem_rdata_in = 4'hf;
		for (int j = 0; j < 4; j++)
		begin
			issue(cise_pkg::CISE_MEMORY_BIT_CLEAR, 4'h0, 4'h0, j[1:0]);
			check("bit clear write", {mem_we_out, mem_wdata_out}, {1'b1, 4'hf & ~(4'h1 << j)});
		end
		idle();
		check("write pulse end", mem_we_out, 1'b0);
		check("bit clear addr", {mem_raddr_out, mem_waddr_out}, {10'h030, 10'h030});
	endtask

	task automatic t_power();
		issue(cise_pkg::CISE_CLOCK_MODE_POWERDOWN);
		check("clock mode unarmed", clock_mode_out, 1'b0);
		issue(cise_pkg::CISE_POWERDOWN_ENABLE);
		issue(cise_pkg::CISE_OTHER);
		issue(cise_pkg::CISE_BACKUP_MODE_POWERDOWN);
		check("backup after gap", backup_mode_out, 1'b0);
		issue(cise_pkg::CISE_POWERDOWN_ENABLE);
		issue(cise_pkg::CISE_CLOCK_MODE_POWERDOWN);
		check("clock mode armed", clock_mode_out, 1'b1);
		issue(cise_pkg::CISE_POWERDOWN_ENABLE);
		check("clock pulse end", clock_mode_out, 1'b0);
		issue(cise_pkg::CISE_BACKUP_MODE_POWERDOWN);
		check("backup armed", backup_mode_out, 1'b1);
	endtask

	task automatic t_portd();
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h0, 4'h3);
		issue(cise_pkg::CISE_PORTD_BIT_CLEAR);
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h0, 4'h7);
		issue(cise_pkg::CISE_PORTD_BIT_CLEAR);
		check("port d bits", port_d_out, 8'h77);
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h0, 4'h9);
		issue(cise_pkg::CISE_PORTD_BIT_CLEAR);
		check("port d y 9", port_d_out, 8'h77);
	endtask

	task automatic t_return();
		logic [`CISE_PC_W-1:0] ret[8];
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'h4, 4'h5);
		issue(cise_pkg::CISE_CARRY_CLEAR);
		b_value_in = 4'h6;
		b_load_in = 1'b1;
		idle();
		b_load_in = 1'b0;
		ret[0] = pc_out;
		irq();
		issue(cise_pkg::CISE_POINTER_IMMEDIATE_LOAD, 4'ha, 4'hb);
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h1);
		b_value_in = 4'h9;
		b_load_in = 1'b1;
		issue(cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY);
		b_load_in = 1'b0;
		issue(cise_pkg::CISE_INTERRUPT_RETURN);
		idle();
		check("state restored", {pc_out, idx_x_out, idx_y_out, idx_z_out, reg_b_out, carry_flag_out, skip_pending_out},
			{ret[0], 4'h4, 4'h5, 2'h0, 4'h6, 1'b0, 1'b0});
		ret[0] = pc_out;
		irq();
		issue(cise_pkg::CISE_RETURN_AND_SKIP);
		idle();
		check("skip return", {pc_out, skip_pending_out}, {ret[0], 1'b1});
		issue(cise_pkg::CISE_ACC_IMMEDIATE_LOAD, 4'h2);
		check("first skipped", acc_out, 4'h0);
		// Eight nested entries, then unwind all of them
		for (int k = 0; k < 8; k++)
		begin
			ret[k] = pc_out;
			irq();
			issue(cise_pkg::CISE_OTHER);
		end
		for (int k = 7; k >= 0; k--)
		begin
			issue(cise_pkg::CISE_SUBROUTINE_RETURN);
			check("ready gap", instr_ready_out, 1'b0);
			idle();
			check("pop pc", pc_out, ret[k]);
		end
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Clock
	always #25 clk_sys_in = ~clk_sys_in;

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys_in);
		#5;
		rst_b_in = 1'b1;
		t_ports();
		t_loads();
		t_rotate();
		t_bitclr();
		t_power();
		t_portd();
		t_return();
		end_of_test();
	end

	// Watchdog, well above the roughly 100 cycles the sequence needs
	initial
	begin
		repeat (3000) @(posedge clk_sys_in);
		error_cnt++;
		end_of_test();
	end
endmodule // tb_cise_exec

bind cise_exec cise_exec_monitor u_mon (.clk_sys_in, .rst_b_in, .instr_valid_in, .instr_op_in, .bit_sel_in,
	.port1_in, .mem_rdata_in, .int_entry_in, .instr_ready_out, .acc_out, .carry_flag_out, .idx_y_out,
	.stack_pointer_out, .skip_pending_out, .port0_out, .mem_wdata_out, .mem_we_out, .clock_mode_out,
	.backup_mode_out);

/* File: rtl/cise_exec.sv */
`timescale 1ns/100ps
`include "cise_params.svh"

// Operation
// - Port output latches accumulator, accumulator unchanged
// - Y increments mod 16, skip when zero
// - Immediate load writes accumulator
// - Pointer load writes X and Y together
// - Only first of consecutive like loads acts
// - Clock-mode powerdown needs enable directly before
// - Backup-mode powerdown needs enable directly before
// - Powerdown enable arms the next instruction only
// - Rotate carry and accumulator right
// - Clear one selected bit of memory nibble
// - Carry clear zeroes carry only
// - Clear port D bit Y, Y 0..7
// - Return pops PC, stack pointer decrements
// - Interrupt return also restores saved state
// - Return then skip first instruction there
// - Return stack is eight entries deep
module cise_exec
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic instr_valid_in,
	input wire cise_pkg::cise_op_t instr_op_in,
	input wire logic [3:0] imm_first_in,
	input wire logic [3:0] imm_second_in,
	input wire logic [1:0] bit_sel_in,
	input wire logic [3:0] port0_in,
	input wire logic [3:0] port1_in,
	input wire logic [3:0] port2_in,
	input wire logic [3:0] mem_rdata_in,
	input wire logic int_entry_in,
	input wire logic [`CISE_PC_W-1:0] int_vector_in,
	input wire logic b_load_in,
	input wire logic [3:0] b_value_in,
	output logic instr_ready_out,
	output logic [`CISE_PC_W-1:0] pc_out,
	output logic [3:0] acc_out,
	output logic carry_flag_out,
	output logic [3:0] idx_x_out,
	output logic [3:0] idx_y_out,
	output logic [1:0] idx_z_out,
	output logic [3:0] reg_b_out,
	output logic [`CISE_SP_W-1:0] stack_pointer_out,
	output logic skip_pending_out,
	output logic [3:0] port0_out,
	output logic [3:0] port1_out,
	output logic [3:0] port2_out,
	output logic [`CISE_PORTD_BITS-1:0] port_d_out,
	output logic [`CISE_DP_W-1:0] mem_raddr_out,
	output logic [`CISE_DP_W-1:0] mem_waddr_out,
	output logic [3:0] mem_wdata_out,
	output logic mem_we_out,
	output logic clock_mode_out,
	output logic backup_mode_out
);

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	cise_pkg::cise_state_t state_q;
	logic [`CISE_PC_W-1:0] pc_q;
	logic [`CISE_SP_W-1:0] sp_q;
	logic [3:0] acc_q;
	logic carry_q;
	logic [3:0] x_q;
	logic [3:0] y_q;
	logic [1:0] z_q;
	logic [3:0] b_q;
	logic skip_q;
	logic last_la_q;
	logic last_lxy_q;
	logic pd_armed_q;
	logic [`CISE_PORTD_BITS-1:0] port_d_q;
	logic [`CISE_PC_W-1:0] stack_rd;
	logic is_rti_q;
	logic is_rts_q;

	// Interrupt save area, one level deep
	logic [3:0] sv_x_q;
	logic [3:0] sv_y_q;
	logic [1:0] sv_z_q;
	logic [3:0] sv_b_q;
	logic sv_carry_q;
	logic sv_skip_q;
	logic sv_la_q;
	logic sv_lxy_q;

	// ----------------------------------------
	// Decode of the presented instruction
	// ----------------------------------------
	logic accept;
	logic take_int;
	logic sup_load;
	logic live;
	logic ret_op;
	logic ret_step;
	logic [3:0] y_inc;

	assign instr_ready_out = (state_q == cise_pkg::CISE_ST_EXEC) && !int_entry_in;
	assign take_int = (state_q == cise_pkg::CISE_ST_EXEC) && int_entry_in;
	assign accept = instr_valid_in && instr_ready_out;
	// Second and later loads of a run are dropped
	assign sup_load = ((instr_op_in == cise_pkg::CISE_ACC_IMMEDIATE_LOAD) && last_la_q) ||
		((instr_op_in == cise_pkg::CISE_POINTER_IMMEDIATE_LOAD) && last_lxy_q);
	assign live = accept && !skip_q && !sup_load;
	assign ret_op = (instr_op_in == cise_pkg::CISE_SUBROUTINE_RETURN) ||
		(instr_op_in == cise_pkg::CISE_INTERRUPT_RETURN) ||
		(instr_op_in == cise_pkg::CISE_RETURN_AND_SKIP);
	assign ret_step = (state_q == cise_pkg::CISE_ST_RET);
	assign y_inc = y_q + 4'h1;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Returns take two cycles: stack read data arrive a cycle later
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= cise_pkg::CISE_ST_EXEC;
			is_rti_q <= 1'b0;
			is_rts_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				cise_pkg::CISE_ST_EXEC:
				begin
					if (live && ret_op)
					begin
						state_q <= cise_pkg::CISE_ST_RET;
						is_rti_q <= (instr_op_in == cise_pkg::CISE_INTERRUPT_RETURN);
						is_rts_q <= (instr_op_in == cise_pkg::CISE_RETURN_AND_SKIP);
					end
				end
				cise_pkg::CISE_ST_RET:
					state_q <= cise_pkg::CISE_ST_EXEC;
				default:
					state_q <= cise_pkg::CISE_ST_EXEC;
			endcase
		end
	end

	// ----------------------------------------
	// Program counter and stack pointer
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pc_q <= `CISE_PC_RST;
			sp_q <= `CISE_SP_RST;
		end
		else if (take_int)
		begin
			pc_q <= int_vector_in;
			sp_q <= sp_q + 3'h1;
		end
		else if (ret_step)
		begin
			pc_q <= stack_rd;
			sp_q <= sp_q - 3'h1;
		end
		else if (accept)
			pc_q <= pc_q + 13'h0001;
	end

	// Eight entries; a ninth push wraps and overwrites the oldest
	cise_stack u_stack
	(
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.wr_en_in(take_int),
		.wr_addr_in(sp_q + 3'h1),
		.wr_data_in(pc_q),
		.rd_addr_in(sp_q),
		.rd_data_out(stack_rd)
	);

	// ----------------------------------------
	// Skip and load-run status
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			skip_q <= 1'b0;
		else if (take_int)
			skip_q <= 1'b0;
		else if (ret_step && is_rti_q)
			skip_q <= sv_skip_q;
		else if (ret_step && is_rts_q)
			skip_q <= 1'b1;
		else if (live && (instr_op_in == cise_pkg::CISE_INDEX_Y_INCREMENT))
			skip_q <= (y_inc == 4'h0);
		else if (accept)
			skip_q <= 1'b0;
	end

	// Run tracking follows every accepted instruction, even dropped ones
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			last_la_q <= 1'b0;
			last_lxy_q <= 1'b0;
		end
		else if (take_int)
		begin
			last_la_q <= 1'b0;
			last_lxy_q <= 1'b0;
		end
		else if (ret_step && is_rti_q)
		begin
			last_la_q <= sv_la_q;
			last_lxy_q <= sv_lxy_q;
		end
		else if (accept)
		begin
			last_la_q <= (instr_op_in == cise_pkg::CISE_ACC_IMMEDIATE_LOAD);
			last_lxy_q <= (instr_op_in == cise_pkg::CISE_POINTER_IMMEDIATE_LOAD);
		end
	end

	// ----------------------------------------
	// Accumulator and carry
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			acc_q <= `CISE_NIB_RST;
		else if (live)
		begin
			unique case (instr_op_in)
				cise_pkg::CISE_PORT0_INPUT_TO_ACC: acc_q <= port0_in;
				cise_pkg::CISE_PORT1_INPUT_TO_ACC: acc_q <= port1_in;
				cise_pkg::CISE_PORT2_INPUT_TO_ACC: acc_q <= port2_in;
				cise_pkg::CISE_ACC_IMMEDIATE_LOAD: acc_q <= imm_first_in;
				cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY:
					acc_q <= {carry_q, acc_q[`CISE_ACC_MSB:1]};
				default: acc_q <= acc_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			carry_q <= 1'b0;
		else if (ret_step && is_rti_q)
			carry_q <= sv_carry_q;
		else if (live && (instr_op_in == cise_pkg::CISE_ROTATE_RIGHT_THROUGH_CARRY))
			carry_q <= acc_q[`CISE_ACC_LSB];
		else if (live && (instr_op_in == cise_pkg::CISE_CARRY_CLEAR))
			carry_q <= 1'b0;
	end

	// ----------------------------------------
	// Data pointer and register B
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			x_q <= `CISE_NIB_RST;
			y_q <= `CISE_NIB_RST;
			z_q <= `CISE_Z_RST;
		end
		else if (ret_step && is_rti_q)
		begin
			x_q <= sv_x_q;
			y_q <= sv_y_q;
			z_q <= sv_z_q;
		end
		else if (live && (instr_op_in == cise_pkg::CISE_POINTER_IMMEDIATE_LOAD))
		begin
			x_q <= imm_first_in;
			y_q <= imm_second_in;
		end
		else if (live && (instr_op_in == cise_pkg::CISE_INDEX_Y_INCREMENT))
			y_q <= y_inc;
	end

	// B is written by the rest of the core outside this subset
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			b_q <= `CISE_NIB_RST;
		else if (ret_step && is_rti_q)
			b_q <= sv_b_q;
		else if (b_load_in)
			b_q <= b_value_in;
	end

	// Save area captured at interrupt entry; nested entry overwrites it
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sv_x_q <= `CISE_NIB_RST;
			sv_y_q <= `CISE_NIB_RST;
			sv_z_q <= `CISE_Z_RST;
			sv_b_q <= `CISE_NIB_RST;
			sv_carry_q <= 1'b0;
			sv_skip_q <= 1'b0;
			sv_la_q <= 1'b0;
			sv_lxy_q <= 1'b0;
		end
		else if (take_int)
		begin
			sv_x_q <= x_q;
			sv_y_q <= y_q;
			sv_z_q <= z_q;
			sv_b_q <= b_q;
			sv_carry_q <= carry_q;
			sv_skip_q <= skip_q;
			sv_la_q <= last_la_q;
			sv_lxy_q <= last_lxy_q;
		end
	end

	// ----------------------------------------
	// Ports
	// ----------------------------------------
	cise_port_reg u_port0
	(
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.load_in(live && (instr_op_in == cise_pkg::CISE_ACC_OUTPUT_TO_PORT0)),
		.data_in(acc_q),
		.port_out(port0_out)
	);

	cise_port_reg u_port1
	(
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.load_in(live && (instr_op_in == cise_pkg::CISE_ACC_OUTPUT_TO_PORT1)),
		.data_in(acc_q),
		.port_out(port1_out)
	);

	cise_port_reg u_port2
	(
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.load_in(live && (instr_op_in == cise_pkg::CISE_ACC_OUTPUT_TO_PORT2)),
		.data_in(acc_q),
		.port_out(port2_out)
	);

	// Y of 8..15 selects no bit, so the port is left alone
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			port_d_q <= `CISE_PORTD_RST;
		else if (live && (instr_op_in == cise_pkg::CISE_PORTD_BIT_CLEAR) && !y_q[3])
			port_d_q[y_q[2:0]] <= 1'b0;
	end

	// ----------------------------------------
	// Memory bit clear, written one cycle later
	// ----------------------------------------
	// Write address is latched so a following pointer load cannot move it
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mem_we_out <= 1'b0;
			mem_wdata_out <= `CISE_NIB_RST;
			mem_waddr_out <= '0;
		end
		else
		begin
			mem_we_out <= live && (instr_op_in == cise_pkg::CISE_MEMORY_BIT_CLEAR);
			mem_wdata_out <= mem_rdata_in & ~(4'h1 << bit_sel_in);
			mem_waddr_out <= {z_q, x_q, y_q};
		end
	end

	// ----------------------------------------
	// Powerdown entry
	// ----------------------------------------
	// Armed only by the instruction right before; any other one disarms
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			pd_armed_q <= 1'b0;
		else if (take_int)
			pd_armed_q <= 1'b0;
		else if (accept)
			pd_armed_q <= live && (instr_op_in == cise_pkg::CISE_POWERDOWN_ENABLE);
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			clock_mode_out <= 1'b0;
			backup_mode_out <= 1'b0;
		end
		else
		begin
			clock_mode_out <= live && pd_armed_q &&
				(instr_op_in == cise_pkg::CISE_CLOCK_MODE_POWERDOWN);
			backup_mode_out <= live && pd_armed_q &&
				(instr_op_in == cise_pkg::CISE_BACKUP_MODE_POWERDOWN);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pc_out = pc_q;
	assign acc_out = acc_q;
	assign carry_flag_out = carry_q;
	assign idx_x_out = x_q;
	assign idx_y_out = y_q;
	assign idx_z_out = z_q;
	assign reg_b_out = b_q;
	assign stack_pointer_out = sp_q;
	assign skip_pending_out = skip_q;
	assign port_d_out = port_d_q;
	assign mem_raddr_out = {z_q, x_q, y_q};

endmodule // cise_exec

/* File: rtl/cise_params.svh */
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CISE_PC_W 13
`define CISE_SP_W 3
`define CISE_STACK_DEPTH 8
`define CISE_PORTD_BITS 8
`define CISE_DP_W 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CISE_PC_RST 13'h0000
`define CISE_SP_RST 3'h7
`define CISE_NIB_RST 4'h0
`define CISE_Z_RST 2'h0
`define CISE_PORT_RST 4'hf
`define CISE_PORTD_RST 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CISE_ACC_MSB 3
`define CISE_ACC_LSB 0

`endif

/* File: rtl/cise_pkg.sv */
package cise_pkg;

	// ----------------------------------------
	// Instruction codes of the subset
	// ----------------------------------------
	typedef enum logic [4:0] {
		CISE_OTHER = 5'h00,
		CISE_PORT0_INPUT_TO_ACC = 5'h01,
		CISE_PORT1_INPUT_TO_ACC = 5'h02,
		CISE_PORT2_INPUT_TO_ACC = 5'h03,
		CISE_ACC_OUTPUT_TO_PORT0 = 5'h04,
		CISE_ACC_OUTPUT_TO_PORT1 = 5'h05,
		CISE_ACC_OUTPUT_TO_PORT2 = 5'h06,
		CISE_INDEX_Y_INCREMENT = 5'h07,
		CISE_ACC_IMMEDIATE_LOAD = 5'h08,
		CISE_POINTER_IMMEDIATE_LOAD = 5'h09,
		CISE_CLOCK_MODE_POWERDOWN = 5'h0a,
		CISE_BACKUP_MODE_POWERDOWN = 5'h0b,
		CISE_POWERDOWN_ENABLE = 5'h0c,
		CISE_ROTATE_RIGHT_THROUGH_CARRY = 5'h0d,
		CISE_MEMORY_BIT_CLEAR = 5'h0e,
		CISE_CARRY_CLEAR = 5'h0f,
		CISE_PORTD_BIT_CLEAR = 5'h10,
		CISE_SUBROUTINE_RETURN = 5'h11,
		CISE_INTERRUPT_RETURN = 5'h12,
		CISE_RETURN_AND_SKIP = 5'h13
	} cise_op_t;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		CISE_ST_EXEC = 2'b01,
		CISE_ST_RET = 2'b10
	} cise_state_t;

endpackage

/* File: rtl/cise_port_reg.sv */
`timescale 1ns/100ps
`include "cise_params.svh"

// Output latch of one 4-bit port
module cise_port_reg
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic load_in,
	input wire logic [3:0] data_in,
	output logic [3:0] port_out
);

	// Latch holds its level until the next output transfer
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			port_out <= `CISE_PORT_RST;
		else if (load_in)
			port_out <= data_in;
	end

endmodule // cise_port_reg

/* File: rtl/cise_stack.sv */
`timescale 1ns/100ps
`include "cise_params.svh"

// Return-address stack with registered read port
module cise_stack
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic wr_en_in,
	input wire logic [`CISE_SP_W-1:0] wr_addr_in,
	input wire logic [`CISE_PC_W-1:0] wr_data_in,
	input wire logic [`CISE_SP_W-1:0] rd_addr_in,
	output logic [`CISE_PC_W-1:0] rd_data_out
);

	logic [`CISE_PC_W-1:0] mem_q [`CISE_STACK_DEPTH];

	// Storage array; no reset so it maps onto plain cells
	always_ff @(posedge clk_sys_in)
	begin
		if (wr_en_in)
			mem_q[wr_addr_in] <= wr_data_in;
	end

	// Read data registered every cycle from the current address
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			rd_data_out <= `CISE_PC_RST;
		else
			rd_data_out <= mem_q[rd_addr_in];
	end

endmodule // cise_stack
